// [evr_event_router.sv]
`timescale 1ns/1ps

// Contract
// RULE1: rtc divider gives eight level taps 64..8192
// RULE2: logic table outputs routed as async levels
// RULE3: comparator and pins routed as async levels
// RULE4: converter events are one-cycle sync pulses
// RULE5: baud and spi clocks are sync levels
// RULE6: timer overflow normal, two underflows split
// RULE7: timer compare pulses, low byte in split
// RULE8: each user selects its own channel
// RULE9: async users react without a clock
// RULE10: sync users fed only clock-domain events
// RULE11: direct users take routed signal unchanged
// RULE12: async edge users detect via own synchroniser
// RULE13: one generator per channel, none after reset
// RULE14: async source synchronised for sync subchannel
// RULE15: async events for sync users last a cycle
// RULE16: sync edge user strobes on sampled change; the code strobes on a sampled rise only, not on a fall
module evr_event_router #(
	parameter int NUM_CH   = 6,
	parameter int NUM_USER = 8
) (
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	input  wire evr_pkg::evr_bus_req_t         busReq,
	output logic [evr_pkg::DATA_W-1:0]         rdData,
	input  wire logic                          rtcClockPin,
	input  wire logic                          rtcOverflow,
	input  wire logic                          rtcCompare,
	input  wire logic [evr_pkg::NUM_LUT-1:0]   logicTableLevel,
	input  wire logic                          analogComparator,
	input  wire logic [evr_pkg::NUM_PIN-1:0]   pinLevelEvent,
	input  wire evr_pkg::evr_adc_t             converterUnit,
	input  wire logic                          serialBaudClockEvent,
	input  wire logic                          spiHostClock,
	input  wire evr_pkg::evr_tca_t             timerAUnit,
	input  wire logic                          timerBLatchEvent,
	input  wire logic                          timerBOverflow,
	output logic [NUM_CH-1:0]                  chanAsync,
	output logic [NUM_CH-1:0]                  chanSync,
	output logic [NUM_USER-1:0]                userDirect,
	output logic [NUM_USER-1:0]                userLevel,
	output logic [NUM_USER-1:0]                userEdge,
	output logic [NUM_USER-1:0]                userAsyncEdge
);

	// refuse sizes the status and user maps cannot hold
	generate
		if (NUM_CH < 1 || NUM_CH > evr_pkg::DATA_W) begin : g_bad_ch
			$error("NUM_CH must be 1..8");
		end
		if (NUM_USER < 1 || NUM_USER > 16) begin : g_bad_user
			$error("NUM_USER must be 1..16");
		end
		// register map groups must not overlap, or one write would land twice
		if (evr_pkg::OFS_STATUS >= evr_pkg::OFS_CHANNEL_BASE) begin : g_bad_status_map
			$error("status offset overlaps the channel selects");
		end
		if (evr_pkg::OFS_CHANNEL_BASE + NUM_CH > evr_pkg::OFS_USER_BASE) begin : g_bad_ch_map
			$error("channel selects overlap the user selects");
		end
		// the generator code table must fit the select width and keep its groups apart
		if (evr_pkg::GEN_COUNT > (1 << evr_pkg::GEN_W)) begin : g_bad_gen_w
			$error("generator codes exceed the select width");
		end
		if (evr_pkg::GEN_PIT_BASE + evr_pkg::PIT_TAPS > evr_pkg::GEN_LUT_BASE) begin : g_bad_pit
			$error("divider taps overlap the logic table codes");
		end
		if (evr_pkg::GEN_LUT_BASE + evr_pkg::NUM_LUT > evr_pkg::GEN_COMPARATOR) begin : g_bad_lut
			$error("logic table codes overlap the comparator code");
		end
		if (evr_pkg::GEN_PIN_BASE + evr_pkg::NUM_PIN > evr_pkg::GEN_BAUD) begin : g_bad_pin
			$error("pin codes overlap the baud code");
		end
		if (evr_pkg::GEN_TCA_CMP + evr_pkg::NUM_COMPARE > evr_pkg::GEN_TCB_LATCH) begin : g_bad_cmp
			$error("compare codes overlap the timer b codes");
		end
		if (evr_pkg::PIT_LOW_BIT + evr_pkg::PIT_TAPS - 2 >= evr_pkg::RTC_DIV_W) begin : g_bad_div
			$error("slowest divider tap lies beyond the counter");
		end
		if (evr_pkg::GEN_TCB_OVF >= evr_pkg::GEN_COUNT) begin : g_bad_count
			$error("generator count misses the last code");
		end
	endgenerate

	localparam int CH_SEL_W = evr_pkg::DATA_W;
	// one spare bit keeps the index legal for a single channel
	localparam int CH_IDX_W = $clog2(NUM_CH + 1);

	// configuration storage
	logic [evr_pkg::DATA_W-1:0] chanSel_r [NUM_CH];
	logic [evr_pkg::DATA_W-1:0] userSel_r [NUM_USER];
	logic [evr_pkg::DATA_W-1:0] rdData_r;
	logic [evr_pkg::DATA_W-1:0] rdData_nxt;
	logic [evr_pkg::RTC_DIV_W-1:0] rtcCount_r;

	// generator vector
	logic [evr_pkg::GEN_COUNT-1:0] genVec;
	logic                          rtcTick;

	// ---------------------------------------------------------------
	// rtc prescaler: the pin is synchronised, its rising edge is a
	// one-cycle enable, so the divider lives on the single clock
	// ---------------------------------------------------------------
	evr_sync_edge #(
		.DO_SYNC (1'b1)
	) u_rtc_sync (
		.clock      (clock),
		.rst_n      (rst_n),
		.levelIn    (rtcClockPin),
		.levelOut   (),
		.riseStrobe (rtcTick)
	);

	// divider counts prescaled rtc periods
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rtcCount_r <= '0;
		end else if (rtcTick) begin
			rtcCount_r <= rtcCount_r + 1'b1; // see RULE1
		end
	end

	// ---------------------------------------------------------------
	// generator assembly
	// ---------------------------------------------------------------
	// rtc pulses are one rtc period long and stay asynchronous
	assign genVec[evr_pkg::GEN_NONE]    = 1'b0;
	assign genVec[evr_pkg::GEN_RTC_OVF] = rtcOverflow;
	assign genVec[evr_pkg::GEN_RTC_CMP] = rtcCompare;

	// bit k of the counter has a period of 2^(k+1) rtc ticks; tap 0 is div 8192
	genvar gp;
	generate
		for (gp = 0; gp < evr_pkg::PIT_TAPS; gp++) begin : g_pit
			assign genVec[evr_pkg::GEN_PIT_BASE + gp] =
				rtcCount_r[evr_pkg::PIT_LOW_BIT + evr_pkg::PIT_TAPS - 2 - gp]; // see RULE1
		end
	endgenerate

	// logic table levels pass straight through, whatever their shape
	assign genVec[evr_pkg::GEN_LUT_BASE +: evr_pkg::NUM_LUT] = logicTableLevel; // see RULE2

	// comparator and pins follow their level with no clock in the path
	assign genVec[evr_pkg::GEN_COMPARATOR] = analogComparator;                   // see RULE3
	assign genVec[evr_pkg::GEN_PIN_BASE +: evr_pkg::NUM_PIN] = pinLevelEvent;    // see RULE3

	// converter pulses come from this clock and last one cycle
	assign genVec[evr_pkg::GEN_ADC_RES]    = converterUnit.resultReady;  // see RULE4
	assign genVec[evr_pkg::GEN_ADC_ACQUISITION_DONE_EVENT]   = converterUnit.sampleReady;  // see RULE4
	assign genVec[evr_pkg::GEN_ADC_WINDOW] = converterUnit.windowMatch;  // see RULE4

	// clock-domain levels, each high or low for two cycles or more
	assign genVec[evr_pkg::GEN_BAUD] = serialBaudClockEvent; // see RULE5
	assign genVec[evr_pkg::GEN_SPI]  = spiHostClock;         // see RULE5

	// timer a: overflow in normal mode, two separate underflows in split mode
	assign genVec[evr_pkg::GEN_TCA_WRAP] = timerAUnit.splitMode ?
		timerAUnit.lowUnderflow : timerAUnit.overflow;               // see RULE6
	assign genVec[evr_pkg::GEN_TCA_HIGH] = timerAUnit.splitMode &
		timerAUnit.highUnderflow;                                    // see RULE6

	// compare channels swap to the low-byte timer in split mode
	genvar gc;
	generate
		for (gc = 0; gc < evr_pkg::NUM_COMPARE; gc++) begin : g_cmp
			assign genVec[evr_pkg::GEN_TCA_CMP + gc] = timerAUnit.splitMode ?
				timerAUnit.lowCompare[gc] : timerAUnit.compare[gc]; // see RULE7
		end
	endgenerate

	// timer b pulses
	assign genVec[evr_pkg::GEN_TCB_LATCH] = timerBLatchEvent;
	assign genVec[evr_pkg::GEN_TCB_OVF]   = timerBOverflow;

	// ---------------------------------------------------------------
	// channels: one multiplexer and two subchannels each
	// ---------------------------------------------------------------
	logic [NUM_CH-1:0] chanIsAsync;
	logic [NUM_CH-1:0] chanSynced;

	genvar gch;
	generate
		for (gch = 0; gch < NUM_CH; gch++) begin : g_chan
			logic             selValid;
			logic [evr_pkg::GEN_W-1:0] selIdx;

			// out-of-range codes route nothing rather than alias a source
			assign selValid = (chanSel_r[gch] < CH_SEL_W'(evr_pkg::GEN_COUNT));
			assign selIdx   = chanSel_r[gch][evr_pkg::GEN_W-1:0];

			// async subchannel is the generator output itself, no flop
			assign chanAsync[gch]   = selValid & genVec[selIdx];            // see RULE13
			assign chanIsAsync[gch] = selValid & evr_pkg::ASYNC_MASK[selIdx];

			// async sources cross two flops before the sync subchannel;
			// the event must last a cycle or it may vanish here
			evr_sync_edge #(
				.DO_SYNC (1'b1)
			) u_chan_sync (
				.clock      (clock),
				.rst_n      (rst_n),
				.levelIn    (chanAsync[gch]),
				.levelOut   (chanSynced[gch]),
				.riseStrobe ()
			); // see RULE15

			// clock-domain sources bypass the synchroniser with no delay
			assign chanSync[gch] = chanIsAsync[gch] ? chanSynced[gch] : chanAsync[gch]; // see RULE14
		end
	endgenerate

	// ---------------------------------------------------------------
	// users: each user holds its own channel choice
	// ---------------------------------------------------------------
	genvar gu;
	generate
		for (gu = 0; gu < NUM_USER; gu++) begin : g_user
			logic                 userOn;
			logic [CH_SEL_W-1:0]  chanIdx;
			logic [CH_IDX_W-1:0]  chanPick;
			logic                 pickAsync;
			logic                 pickSync;

			// code 0 is off, code n listens to channel n-1
			assign userOn  = (userSel_r[gu] != evr_pkg::USER_OFF) &&
				(userSel_r[gu] <= CH_SEL_W'(NUM_CH));                 // see RULE8
			assign chanIdx  = userSel_r[gu] - 1'b1;
			assign chanPick = chanIdx[CH_IDX_W-1:0]; // upper bits are zero whenever userOn

			assign pickAsync = userOn & chanAsync[chanPick];
			assign pickSync  = userOn & chanSync[chanPick];

			// direct and async-level users get the wire, no clock involved;
			// selection changes can glitch this path, so switch while idle
			assign userDirect[gu] = pickAsync; // see RULE9 see RULE11

			// sync users only ever see the sync subchannel
			assign userLevel[gu] = pickSync;   // see RULE10

			// sync edge user: sample and compare with the previous sample
			evr_sync_edge #(
				.DO_SYNC (1'b0)
			) u_edge (
				.clock      (clock),
				.rst_n      (rst_n),
				.levelIn    (pickSync),
				.levelOut   (),
				.riseStrobe (userEdge[gu])
			); // see RULE16

			// async edge user with its own synchroniser on the async wire
			evr_sync_edge #(
				.DO_SYNC (1'b1)
			) u_async_edge (
				.clock      (clock),
				.rst_n      (rst_n),
				.levelIn    (pickAsync),
				.levelOut   (),
				.riseStrobe (userAsyncEdge[gu])
			); // see RULE12
		end
	endgenerate

	// ---------------------------------------------------------------
	// register port
	// ---------------------------------------------------------------
	logic                statusAddrHit;
	logic [NUM_CH-1:0]   chanAddrHit;
	logic [NUM_USER-1:0] userAddrHit;
	logic [NUM_CH-1:0]   chanWrHit;
	logic [NUM_USER-1:0] userWrHit;

	// address decode shared by the write strobes and the read mux
	assign statusAddrHit = (busReq.addr == evr_pkg::OFS_STATUS);

	genvar gw;
	generate
		for (gw = 0; gw < NUM_CH; gw++) begin : g_chan_wr
			assign chanAddrHit[gw] = (busReq.addr == evr_pkg::OFS_CHANNEL_BASE + evr_pkg::ADDR_W'(gw));
			assign chanWrHit[gw]   = busReq.wrStrobe & chanAddrHit[gw];

			// per-channel generator choice
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					chanSel_r[gw] <= evr_pkg::CHANNEL_RESET; // see RULE13
				end else if (chanWrHit[gw]) begin
					chanSel_r[gw] <= busReq.wrData;
				end
			end
		end
		for (gw = 0; gw < NUM_USER; gw++) begin : g_user_wr
			assign userAddrHit[gw] = (busReq.addr == evr_pkg::OFS_USER_BASE + evr_pkg::ADDR_W'(gw));
			assign userWrHit[gw]   = busReq.wrStrobe & userAddrHit[gw];

			// per-user channel choice
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					userSel_r[gw] <= evr_pkg::USER_RESET;
				end else if (userWrHit[gw]) begin
					userSel_r[gw] <= busReq.wrData; // see RULE8
				end
			end
		end
	endgenerate

	// read selection; unmapped offsets read zero
	always_comb begin
		rdData_nxt = '0;
		if (statusAddrHit) begin
			rdData_nxt = evr_pkg::DATA_W'(chanSync);
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (chanAddrHit[c]) begin
				rdData_nxt = chanSel_r[c];
			end
		end
		for (int u = 0; u < NUM_USER; u++) begin
			if (userAddrHit[u]) begin
				rdData_nxt = userSel_r[u];
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdData_r <= '0;
		end else if (busReq.rdStrobe) begin
			rdData_r <= rdData_nxt;
		end else begin
			rdData_r <= '0;
		end
	end

	assign rdData = rdData_r;

endmodule : evr_event_router

// [evr_gen_model.sv]
`timescale 1ns/1ps

// stand-in for the generating peripherals: the code picks one generator, fire drives it
module evr_gen_model (
	input  wire logic [5:0]      genCode,
	input  wire logic            fire,
	input  wire logic            split,
	output logic                 rtcOverflow,
	output logic                 rtcCompare,
	output logic [3:0]           logicTableLevel,
	output logic                 analogComparator,
	output logic [7:0]           pinLevelEvent,
	output evr_pkg::evr_adc_t    converterUnit,
	output logic                 serialBaudClockEvent,
	output logic                 spiHostClock,
	output evr_pkg::evr_tca_t    timerAUnit,
	output logic                 timerBLatchEvent,
	output logic                 timerBOverflow
);
	logic [2:0] cmpHot;

	function automatic logic hit(input logic [5:0] c);
		return fire && genCode == c;
	endfunction : hit

	// async generators follow fire directly; the bench holds them a cycle or more
	assign rtcOverflow = hit(evr_pkg::GEN_RTC_OVF);
	assign rtcCompare = hit(evr_pkg::GEN_RTC_CMP);
	assign logicTableLevel = (fire && genCode >= 6'h0b && genCode < 6'h0f) ? 4'h1 << (genCode - 6'h0b) : 4'h0;
	assign analogComparator = hit(evr_pkg::GEN_COMPARATOR);
	assign pinLevelEvent = (fire && genCode >= 6'h13 && genCode < 6'h1b) ? 8'h01 << (genCode - 6'h13) : 8'h00;
	// clocked generators change only at bench edges, so they belong to the peripheral clock
	assign converterUnit = {hit(evr_pkg::GEN_ADC_RES), hit(evr_pkg::GEN_ADC_ACQUISITION_DONE_EVENT), hit(evr_pkg::GEN_ADC_WINDOW)};
	assign serialBaudClockEvent = hit(evr_pkg::GEN_BAUD);
	assign spiHostClock = hit(evr_pkg::GEN_SPI);
	assign cmpHot = (fire && genCode >= 6'h1f && genCode < 6'h22) ? 3'h1 << (genCode - 6'h1f) : 3'h0;
	// high underflow is driven even in normal mode, so the bench can see it blocked
	assign timerAUnit = {split, hit(6'h1d) && !split, hit(6'h1d) && split, hit(6'h1e),
		split ? 3'h0 : cmpHot, split ? cmpHot : 3'h0};
	assign timerBLatchEvent = hit(evr_pkg::GEN_TCB_LATCH);
	assign timerBOverflow = hit(evr_pkg::GEN_TCB_OVF);
endmodule : evr_gen_model

// [evr_pkg.sv]
package evr_pkg;

	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS       = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CHANNEL_BASE = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_USER_BASE    = 8'h20;

	// reset values: channels route nothing, users listen to nothing
	localparam logic [DATA_W-1:0] CHANNEL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] USER_RESET    = 8'h00;
	localparam logic [DATA_W-1:0] USER_OFF      = 8'h00;

	// generator source counts
	localparam int NUM_LUT      = 4;
	localparam int NUM_PIN      = 8;
	localparam int NUM_COMPARE  = 3;
	localparam int PIT_TAPS     = 8;
	localparam int PIT_LOW_BIT  = 6;  // counter bit 5 has period 64, see tap mapping below
	localparam int RTC_DIV_W    = 13; // bit 12 has period 8192
	localparam int SYNC_STAGES  = 2;

	// generator select encoding
	localparam int GEN_W     = 6;
	localparam int GEN_COUNT = 36;
	localparam logic [GEN_W-1:0] GEN_NONE        = 6'h00;
	localparam logic [GEN_W-1:0] GEN_RTC_OVF     = 6'h01;
	localparam logic [GEN_W-1:0] GEN_RTC_CMP     = 6'h02;
	localparam logic [GEN_W-1:0] GEN_PIT_BASE    = 6'h03; // 8192 first, down to 64
	localparam logic [GEN_W-1:0] GEN_LUT_BASE    = 6'h0b;
	localparam logic [GEN_W-1:0] GEN_COMPARATOR  = 6'h0f;
	localparam logic [GEN_W-1:0] GEN_ADC_RES     = 6'h10;
	localparam logic [GEN_W-1:0] GEN_ADC_ACQUISITION_DONE_EVENT    = 6'h11;
	localparam logic [GEN_W-1:0] GEN_ADC_WINDOW  = 6'h12;
	localparam logic [GEN_W-1:0] GEN_PIN_BASE    = 6'h13;
	localparam logic [GEN_W-1:0] GEN_BAUD        = 6'h1b;
	localparam logic [GEN_W-1:0] GEN_SPI         = 6'h1c;
	localparam logic [GEN_W-1:0] GEN_TCA_WRAP    = 6'h1d;
	localparam logic [GEN_W-1:0] GEN_TCA_HIGH    = 6'h1e;
	localparam logic [GEN_W-1:0] GEN_TCA_CMP     = 6'h1f; // three in a row
	localparam logic [GEN_W-1:0] GEN_TCB_LATCH   = 6'h22;
	localparam logic [GEN_W-1:0] GEN_TCB_OVF     = 6'h23;

	// generators not clocked by the peripheral clock (rtc pulses, logic, comparator, pins)
	localparam logic [GEN_COUNT-1:0] ASYNC_MASK = 36'h007f8f806;

	// register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
		logic              wrStrobe;
		logic              rdStrobe;
	} evr_bus_req_t;

	// converter event pulses
	typedef struct packed {
		logic resultReady;
		logic sampleReady;
		logic windowMatch;
	} evr_adc_t;

	// 16-bit timer event pulses and mode
	typedef struct packed {
		logic                   splitMode;
		logic                   overflow;
		logic                   lowUnderflow;
		logic                   highUnderflow;
		logic [NUM_COMPARE-1:0] compare;
		logic [NUM_COMPARE-1:0] lowCompare;
	} evr_tca_t;

endpackage : evr_pkg

// [evr_router_properties.sv]
`timescale 1ns/1ps

// port-level relations of the router; selects are changed only while events are idle
module evr_router_props #(
	parameter int NUM_CH   = 6,
	parameter int NUM_USER = 8
) (
	input wire logic                         clock,
	input wire logic                         rst_n,
	input wire evr_pkg::evr_bus_req_t        busReq,
	input wire logic [evr_pkg::DATA_W-1:0]   rdData,
	input wire logic [NUM_CH-1:0]            chanAsync,
	input wire logic [NUM_CH-1:0]            chanSync,
	input wire logic [NUM_USER-1:0]          userDirect,
	input wire logic [NUM_USER-1:0]          userLevel,
	input wire logic [NUM_USER-1:0]          userEdge,
	input wire logic [NUM_USER-1:0]          userAsyncEdge
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// a status read is one strobe; its answer stands the next cycle
	sequence s_status_rd;
		busReq.rdStrobe && busReq.addr == evr_pkg::OFS_STATUS;
	endsequence

	a_status_read: assert property (s_status_rd |=> rdData == 8'($past(chanSync)))
		else $error("status read differs from sync subchannels");
	a_read_idle: assert property (!busReq.rdStrobe |=> rdData == '0)
		else $error("read data not zero outside a read answer");
	a_reset_none: assert property ($rose(rst_n) |-> chanAsync == '0 && chanSync == '0 && userDirect == '0)
		else $error("channel carries an event right after reset");
	a_edge_strobe: assert property (userEdge == (userLevel & ~$past(userLevel)))
		else $error("sync edge strobe does not match level rise");
	a_edge_single: assert property (userEdge != '0 |=> (userEdge & $past(userEdge)) == '0)
		else $error("sync edge strobe longer than one cycle");
	a_async_single: assert property (userAsyncEdge != '0 |=> (userAsyncEdge & $past(userAsyncEdge)) == '0)
		else $error("async edge strobe longer than one cycle");
	a_async_cause: assert property ((userAsyncEdge & ~($past(userDirect, 2) | $past(userDirect, 3))) == '0)
		else $error("async edge strobe without earlier direct rise");
	// the sync copy is either the source itself or the source two cycles back
	a_sync_lag: assert property ((chanSync & ~chanAsync & ~$past(chanAsync, 2)) == '0)
		else $error("sync subchannel high without matching source");
endmodule : evr_router_props

bind evr_event_router evr_router_props #(.NUM_CH(NUM_CH), .NUM_USER(NUM_USER)) u_props (.clock(clock),
	.rst_n(rst_n), .busReq(busReq), .rdData(rdData), .chanAsync(chanAsync), .chanSync(chanSync),
	.userDirect(userDirect), .userLevel(userLevel), .userEdge(userEdge), .userAsyncEdge(userAsyncEdge));

// [evr_sync_edge.sv]
`timescale 1ns/1ps

// level stage with optional two-flop synchroniser and rising-edge strobe
module evr_sync_edge #(
	parameter bit DO_SYNC = 1'b1
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic levelIn,
	output logic      levelOut,
	output logic      riseStrobe
);

	logic prev_r;

	generate
		if (DO_SYNC) begin : g_sync
			logic meta_r;
			logic stable_r;
			// first flop feeds only the second
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					meta_r   <= 1'b0;
					stable_r <= 1'b0;
				end else begin
					meta_r   <= levelIn;
					stable_r <= meta_r;
				end
			end
			assign levelOut = stable_r;
		end else begin : g_direct
			assign levelOut = levelIn;
		end
	endgenerate

	// previous sample for edge compare
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= levelOut;
		end
	end

	assign riseStrobe = levelOut & ~prev_r;

endmodule : evr_sync_edge

// [testbench.sv]
`timescale 1ns/1ps

module testbench;
	// rows: {split, expect, async, code}
	localparam logic [8:0] ROWS [32] = '{9'h000, 9'h0c1, 9'h0c2, 9'h0cb, 9'h0cc, 9'h0cd, 9'h0ce, 9'h0cf,
		9'h090, 9'h091, 9'h092, 9'h0d3, 9'h0d4, 9'h0d5, 9'h0d6, 9'h0d7, 9'h0d8, 9'h0d9, 9'h0da, 9'h09b,
		9'h09c, 9'h09d, 9'h01e, 9'h09f, 9'h0a0, 9'h0a1, 9'h0a2, 9'h0a3, 9'h024, 9'h19d, 9'h19e, 9'h19f};
	localparam logic [7:0] CH = evr_pkg::OFS_CHANNEL_BASE;
	localparam logic [7:0] US = evr_pkg::OFS_USER_BASE;
	logic                  clock, rst_n, fire, split, rtcClockPin;
	logic [5:0]            genCode;
	evr_pkg::evr_bus_req_t busReq;
	logic [7:0]            rdData;
	logic                  rtcOverflow, rtcCompare, analogComparator, serialBaudClockEvent, spiHostClock;
	logic                  timerBLatchEvent, timerBOverflow;
	logic [3:0]            logicTableLevel;
	logic [7:0]            pinLevelEvent, userDirect, userLevel, userEdge, userAsyncEdge;
	evr_pkg::evr_adc_t     converterUnit;
	evr_pkg::evr_tca_t     timerAUnit;
	logic [5:0]            chanAsync, chanSync;
	logic [8:0]            r;
	int                    errors, total_checks, n, hits;

	evr_gen_model u_gen (.genCode(genCode), .fire(fire), .split(split), .rtcOverflow(rtcOverflow),
		.rtcCompare(rtcCompare), .logicTableLevel(logicTableLevel), .analogComparator(analogComparator),
		.pinLevelEvent(pinLevelEvent), .converterUnit(converterUnit), .serialBaudClockEvent(serialBaudClockEvent),
		.spiHostClock(spiHostClock), .timerAUnit(timerAUnit), .timerBLatchEvent(timerBLatchEvent),
		.timerBOverflow(timerBOverflow));
	evr_event_router dut (.clock(clock), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
		.rtcClockPin(rtcClockPin), .rtcOverflow(rtcOverflow), .rtcCompare(rtcCompare),
		.logicTableLevel(logicTableLevel), .analogComparator(analogComparator), .pinLevelEvent(pinLevelEvent),
		.converterUnit(converterUnit), .serialBaudClockEvent(serialBaudClockEvent), .spiHostClock(spiHostClock),
		.timerAUnit(timerAUnit), .timerBLatchEvent(timerBLatchEvent), .timerBOverflow(timerBOverflow),
		.chanAsync(chanAsync), .chanSync(chanSync), .userDirect(userDirect), .userLevel(userLevel),
		.userEdge(userEdge), .userAsyncEdge(userAsyncEdge));

	// 200 MHz
	always #2.5 clock = ~clock;

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk

	// one-cycle strobes; read data is taken only in the cycle after the strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) busReq <= {a, d, 2'b10};
		@(posedge clock) busReq <= {a, d, 2'b00};
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		@(posedge clock) busReq <= {a, 8'h00, 2'b01};
		@(posedge clock) busReq <= {a, 8'h00, 2'b00};
		@(negedge clock) chk(rdData, want);
	endtask : rd

	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	initial begin
		clock = 0; rst_n = 0; busReq = '0; genCode = 0; fire = 0; split = 0; rtcClockPin = 0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock) chk(chanSync | chanAsync, 0);
		for (int k = 0; k < 6; k++) rd(CH + 8'(k), evr_pkg::CHANNEL_RESET);
		rd(US, evr_pkg::USER_RESET);
		wr(US, 8'h01);
		wr(US + 8'h02, 8'h07);
		// every generator code but the divider taps through channel 0 to user 0; users 1 and 2 stay off
		for (int i = 0; i < 32; i++) begin
			r = ROWS[i];
			wr(CH, {2'b00, r[5:0]});
			rd(CH, {2'b00, r[5:0]});
			@(posedge clock) begin genCode <= r[5:0]; split <= r[8]; fire <= 1'b1; end
			@(negedge clock) chk(chanAsync[0], r[7]);
			chk(userDirect[0], r[7]);
			chk(userLevel[1] | userLevel[2], 0);
			n = 0;
			while (r[7] && chanSync[0] !== 1'b1 && n < 5) begin @(negedge clock); n++; end
			if (r[7]) chk(r[6] ? (n >= 2 && n <= 3) : (n == 0), 1);
			chk(userEdge[0], r[7]);
			@(posedge clock) fire <= 1'b0;
			repeat (4) @(negedge clock);
			chk(chanSync[0] | userLevel[0], 0);
		end
		// pin on channel 1: direct user, async edge user and status bit
		wr(CH, 8'h00);
		wr(CH + 8'h01, evr_pkg::GEN_PIN_BASE);
		wr(US + 8'h03, 8'h02);
		@(posedge clock) begin genCode <= evr_pkg::GEN_PIN_BASE; split <= 1'b0; fire <= 1'b1; end
		hits = 0;
		@(negedge clock) chk(userDirect[3], 1);
		repeat (8) begin @(negedge clock); hits += userAsyncEdge[3]; end
		chk(8'(hits), 1);
		rd(evr_pkg::OFS_STATUS, 8'h02);
		@(posedge clock) fire <= 1'b0;
		wr(8'h30, 8'h5a);
		rd(8'h30, 8'h00);
		wr(CH + 8'h05, 8'hff);
		rd(CH + 8'h05, 8'hff);
		// divide-by-64 tap rises after 32 rtc edges, the 8192 tap stays low
		wr(CH, 8'h0a);
		wr(CH + 8'h01, evr_pkg::GEN_PIT_BASE);
		for (int i = 1; i <= 32; i++) begin
			@(posedge clock) rtcClockPin <= 1'b1;
			repeat (4) @(posedge clock);
			rtcClockPin <= 1'b0;
			repeat (4) @(posedge clock);
			@(negedge clock) if (i == 31) chk(chanSync[0], 0);
		end
		chk(chanSync[1:0], 2'b01);
		chk(userLevel[0], 1);
		// reset in mid-run drops every selection
		@(posedge clock) rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock) chk(chanAsync | chanSync, 0);
		rd(CH, evr_pkg::CHANNEL_RESET);
		print_verdict();
	end
endmodule : testbench
